// ---- design/swsa_map.vh ----
`ifndef SWSA_MAP_VH
`define SWSA_MAP_VH

// ****************************************************************
// Clock and microsecond tick
// ****************************************************************
`define SWSA_CLK_MHZ       8'hc8
`define SWSA_US_LAST       (`SWSA_CLK_MHZ - 8'h01)

// ****************************************************************
// Line timing, in microseconds
// ****************************************************************
`define SWSA_RST_MIN_US    10'h1e0
`define SWSA_PRES_WAIT_US  8'h1e
`define SWSA_PRES_LOW_US   8'h78
`define SWSA_WR_SAMPLE_US  8'h1e
`define SWSA_RD_HOLD_US    8'h1e

// ****************************************************************
// Commands
// ****************************************************************
`define SWSA_CMD_SKIP      8'hcc
`define SWSA_CMD_RECALL    8'hb8
`define SWSA_CMD_READSP    8'hbe

// ****************************************************************
// Scratchpad layout
// ****************************************************************
`define SWSA_SP_DATA       4'h8
`define SWSA_PAGE_ICA      3'h1
`define SWSA_OFS_ICA       3'h4
`define SWSA_PAGE_ACC      3'h7
`define SWSA_OFS_CHG_LO    3'h4
`define SWSA_OFS_CHG_HI    3'h5
`define SWSA_OFS_DIS_LO    3'h6
`define SWSA_OFS_DIS_HI    3'h7
`define SWSA_CRC_POLY      8'h8c

`endif

// ---- design/swsa_buf2.v ----
`timescale 1ns/1ps
module swsa_buf2 #(
  parameter W = 8
) (
  input  wire         clk,
  input  wire         sys_rst,
  input  wire         clr,
  input  wire         inValid,
  output wire         inReady,
  input  wire [W-1:0] inData,
  output wire         outValid,
  input  wire         outReady,
  output wire [W-1:0] outData
);
  reg [1:0]   cnt_r;
  reg [W-1:0] d0_r;
  reg [W-1:0] d1_r;
  wire        push;
  wire        pop;

  assign inReady  = (cnt_r != 2'h2);
  assign outValid = (cnt_r != 2'h0);
  assign outData  = d0_r;
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always @(posedge clk) begin
    if (sys_rst || clr) begin
      cnt_r <= 2'h0;
    end else if (push && !pop) begin
      cnt_r <= cnt_r + 2'h1;
    end else if (pop && !push) begin
      cnt_r <= cnt_r - 2'h1;
    end
  end

  // Data words need no reset; valid comes from the count
  always @(posedge clk) begin
    if (push && !pop) begin
      if (cnt_r == 2'h0) begin
        d0_r <= inData;
      end else begin
        d1_r <= inData;
      end
    end else if (pop && !push) begin
      d0_r <= d1_r;
    end else if (pop && push) begin
      if (cnt_r == 2'h1) begin
        d0_r <= inData;
      end else begin
        d0_r <= d1_r;
        d1_r <= inData;
      end
    end
  end
endmodule

// ---- design/swsa_slave.v ----
// How it works
// - Master starts every line signal; this end drives the presence pulse and zero read bits.
// - Nothing is accepted until a reset pulse has been answered by presence.
// - After reset rises, wait 15-60 us, then pull low 60-240 us.
// - Write bit sampled 15-60 us after slot fall; high is one.
// - Read bit appears on the line within 14 us of slot fall.
// - Page 01h recall and read returns integrated total at byte 04h.
// - Page 07h returns charge at 04h-05h, discharge at 06h-07h, CRC.
// - Read scratchpad returns nine bytes of the page, CRC last.
`timescale 1ns/1ps
`include "swsa_map.vh"
module swsa_slave (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        dqIn,
  output wire        dqOut,
  output wire        dqOeN,
  input  wire        memWrEn,
  input  wire [5:0]  memWrAddr,
  input  wire [7:0]  memWrData,
  input  wire [7:0]  integratedCurrentTotal,
  input  wire [15:0] chargeTotalCounter,
  input  wire [15:0] dischargeTotalCounter,
  output reg         recallPulse_r,
  output reg  [2:0]  recallPage_r
);
  // ****************************************************************
  // States
  // ****************************************************************
  localparam ST_IDLE  = 8'h01;
  localparam ST_PWAIT = 8'h02;
  localparam ST_PRES  = 8'h04;
  localparam ST_ROM   = 8'h08;
  localparam ST_FUNC  = 8'h10;
  localparam ST_PAGE  = 8'h20;
  localparam ST_TX    = 8'h40;
  localparam ST_DONE  = 8'h80;

  reg  [7:0]  state_r;
  reg         dqS1_r;
  reg         dqS2_r;
  reg         dqS3_r;
  reg  [7:0]  divCnt_r;
  reg  [9:0]  lowUs_r;
  reg  [7:0]  tmr_r;
  reg         rstSeen_r;
  reg         drv_r;
  reg         slot_r;
  reg  [7:0]  sh_r;
  reg  [2:0]  bitCnt_r;
  reg  [7:0]  cmd_r;
  reg  [2:0]  page_r;
  reg  [3:0]  byteCnt_r;
  reg  [3:0]  fetchIdx_r;
  reg         loaded_r;
  reg  [7:0]  crc_r;
  reg  [7:0]  icaSnap_r;
  reg  [15:0] chgSnap_r;
  reg  [15:0] disSnap_r;
  reg  [7:0]  mem [0:63];
  reg  [7:0]  pageByte;
  wire        fall;
  wire        rise;
  wire        usTick;
  wire        rxDone;
  wire [7:0]  rxByte;
  wire        bufInValid;
  wire        bufInReady;
  wire [7:0]  bufInData;
  wire        bufOutValid;
  wire        bufOutReady;
  wire [7:0]  bufOutData;
  wire        inTx;

  // Open drain: only ever pulls low
  assign dqOut = 1'b0;
  assign dqOeN = ~drv_r;

  // ****************************************************************
  // Line synchroniser and edges
  // ****************************************************************
  always @(posedge clk) begin
    if (sys_rst) begin
      dqS1_r <= 1'b1;
      dqS2_r <= 1'b1;
      dqS3_r <= 1'b1;
    end else begin
      dqS1_r <= dqIn;
      dqS2_r <= dqS1_r;
      dqS3_r <= dqS2_r;
    end
  end

  assign fall = dqS3_r & ~dqS2_r;
  assign rise = ~dqS3_r & dqS2_r;

  // ****************************************************************
  // Microsecond tick and low-time counter
  // ****************************************************************
  assign usTick = (divCnt_r == `SWSA_US_LAST);

  always @(posedge clk) begin
    if (sys_rst || usTick) begin
      divCnt_r <= 8'h00;
    end else begin
      divCnt_r <= divCnt_r + 8'h01;
    end
  end

  // Saturates so a stuck-low bus cannot wrap into a false idle
  always @(posedge clk) begin
    if (sys_rst || dqS2_r) begin
      lowUs_r <= 10'h000;
    end else if (usTick && lowUs_r != 10'h3ff) begin
      lowUs_r <= lowUs_r + 10'h001;
    end
  end

  // ****************************************************************
  // Scratchpad store and read mux
  // ****************************************************************
  always @(posedge clk) begin
    if (memWrEn) begin
      mem[memWrAddr] <= memWrData;
    end
  end

  always @* begin
    pageByte = mem[{page_r, fetchIdx_r[2:0]}];
    if (page_r == `SWSA_PAGE_ICA &&
        fetchIdx_r[2:0] == `SWSA_OFS_ICA) begin
      pageByte = icaSnap_r;
    end
    if (page_r == `SWSA_PAGE_ACC) begin
      case (fetchIdx_r[2:0])
        `SWSA_OFS_CHG_LO: pageByte = chgSnap_r[7:0];
        `SWSA_OFS_CHG_HI: pageByte = chgSnap_r[15:8];
        `SWSA_OFS_DIS_LO: pageByte = disSnap_r[7:0];
        `SWSA_OFS_DIS_HI: pageByte = disSnap_r[15:8];
        default: pageByte = mem[{page_r, fetchIdx_r[2:0]}];
      endcase
    end
  end

  // ****************************************************************
  // Transmit buffer
  // ****************************************************************
  // Feeder runs ahead of the line; the CRC waits for the last data bit
  assign inTx        = state_r[6];
  assign bufInValid  = inTx && ((fetchIdx_r < `SWSA_SP_DATA) ||
                       (fetchIdx_r == `SWSA_SP_DATA &&
                        byteCnt_r == `SWSA_SP_DATA));
  assign bufInData   = (fetchIdx_r == `SWSA_SP_DATA) ? crc_r : pageByte;
  assign bufOutReady = inTx && !loaded_r;

  swsa_buf2 #(.W(8)) u_buf (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .clr      (~inTx),
    .inValid  (bufInValid),
    .inReady  (bufInReady),
    .inData   (bufInData),
    .outValid (bufOutValid),
    .outReady (bufOutReady),
    .outData  (bufOutData)
  );

  // ****************************************************************
  // Slot engine and command sequencer
  // ****************************************************************
  assign rxByte = {dqS2_r, sh_r[7:1]};
  assign rxDone = slot_r && tmr_r == `SWSA_WR_SAMPLE_US &&
                  bitCnt_r == 3'h7;

  always @(posedge clk) begin
    if (sys_rst) begin
      state_r       <= ST_IDLE;
      tmr_r         <= 8'h00;
      rstSeen_r     <= 1'b0;
      drv_r         <= 1'b0;
      slot_r        <= 1'b0;
      sh_r          <= 8'h00;
      bitCnt_r      <= 3'h0;
      cmd_r         <= 8'h00;
      page_r        <= 3'h0;
      byteCnt_r     <= 4'h0;
      fetchIdx_r    <= 4'h0;
      loaded_r      <= 1'b0;
      crc_r         <= 8'h00;
      icaSnap_r     <= 8'h00;
      chgSnap_r     <= 16'h0000;
      disSnap_r     <= 16'h0000;
      recallPulse_r <= 1'b0;
      recallPage_r  <= 3'h0;
    end else begin
      recallPulse_r <= 1'b0;
      if (usTick && tmr_r != 8'hff) begin
        tmr_r <= tmr_r + 8'h01;
      end
      if (bufInValid && bufInReady) begin
        fetchIdx_r <= fetchIdx_r + 4'h1;
      end
      if (!dqS2_r && usTick &&
          lowUs_r == `SWSA_RST_MIN_US - 10'h001) begin
        rstSeen_r <= 1'b1;
        state_r   <= ST_IDLE;
        drv_r     <= 1'b0;
        slot_r    <= 1'b0;
      end else begin
        case (state_r)
          ST_IDLE: begin
            if (rise && rstSeen_r) begin
              rstSeen_r <= 1'b0;
              tmr_r     <= 8'h00;
              state_r   <= ST_PWAIT;
            end
          end
          ST_PWAIT: begin
            if (tmr_r == `SWSA_PRES_WAIT_US) begin
              drv_r   <= 1'b1;
              tmr_r   <= 8'h00;
              state_r <= ST_PRES;
            end
          end
          ST_PRES: begin
            if (tmr_r == `SWSA_PRES_LOW_US) begin
              drv_r    <= 1'b0;
              slot_r   <= 1'b0;
              bitCnt_r <= 3'h0;
              state_r  <= ST_ROM;
            end
          end
          ST_ROM, ST_FUNC, ST_PAGE: begin
            if (fall && !slot_r) begin
              slot_r <= 1'b1;
              tmr_r  <= 8'h00;
            end else if (slot_r && tmr_r == `SWSA_WR_SAMPLE_US) begin
              slot_r   <= 1'b0;
              sh_r     <= rxByte;
              bitCnt_r <= bitCnt_r + 3'h1;
            end
            if (rxDone && state_r == ST_ROM) begin
              state_r <= (rxByte == `SWSA_CMD_SKIP) ? ST_FUNC : ST_DONE;
            end
            if (rxDone && state_r == ST_FUNC) begin
              cmd_r   <= rxByte;
              state_r <= (rxByte == `SWSA_CMD_RECALL ||
                          rxByte == `SWSA_CMD_READSP) ? ST_PAGE : ST_DONE;
            end
            if (rxDone && state_r == ST_PAGE) begin
              page_r <= rxByte[2:0];
              if (rxByte[7:3] != 5'h00) begin
                state_r <= ST_DONE;
              end else if (cmd_r == `SWSA_CMD_RECALL) begin
                recallPulse_r <= 1'b1;
                recallPage_r  <= rxByte[2:0];
                if (rxByte[2:0] == `SWSA_PAGE_ICA) begin
                  icaSnap_r <= integratedCurrentTotal;
                end
                if (rxByte[2:0] == `SWSA_PAGE_ACC) begin
                  chgSnap_r <= chargeTotalCounter;
                  disSnap_r <= dischargeTotalCounter;
                end
                state_r <= ST_DONE;
              end else begin
                byteCnt_r  <= 4'h0;
                fetchIdx_r <= 4'h0;
                loaded_r   <= 1'b0;
                crc_r      <= 8'h00;
                state_r    <= ST_TX;
              end
            end
          end
          ST_TX: begin
            if (bufOutValid && !loaded_r) begin
              sh_r     <= bufOutData;
              loaded_r <= 1'b1;
              bitCnt_r <= 3'h0;
            end
            // A slot with no byte loaded simply reads as one
            if (fall && !slot_r && loaded_r) begin
              slot_r <= 1'b1;
              tmr_r  <= 8'h00;
              drv_r  <= ~sh_r[0];
              crc_r  <= {1'b0, crc_r[7:1]} ^
                        ((crc_r[0] ^ sh_r[0]) ? `SWSA_CRC_POLY : 8'h00);
            end else if (slot_r && tmr_r == `SWSA_RD_HOLD_US) begin
              drv_r    <= 1'b0;
              slot_r   <= 1'b0;
              sh_r     <= {1'b0, sh_r[7:1]};
              bitCnt_r <= bitCnt_r + 3'h1;
              if (bitCnt_r == 3'h7) begin
                loaded_r  <= 1'b0;
                byteCnt_r <= byteCnt_r + 4'h1;
                if (byteCnt_r == `SWSA_SP_DATA) begin
                  state_r <= ST_DONE;
                end
              end
            end
          end
          ST_DONE: begin
            drv_r <= 1'b0;
          end
          default: begin
            state_r <= ST_IDLE;
            drv_r   <= 1'b0;
          end
        endcase
      end
    end
  end
endmodule

// ---- bench/swsa_slave_chk.sv ----
`timescale 1ns/1ps
module swsa_slave_chk (
  input wire        clk,
  input wire        sys_rst,
  input wire        dqIn,
  input wire        dqOut,
  input wire        dqOeN,
  input wire        recallPulse_r,
  input wire [2:0]  recallPage_r
);
  // ********************************
  // Interval counters on the wire
  // ********************************
  reg [16:0] oeLowCnt_r;
  reg [16:0] hiCnt_r;
  reg [16:0] loCnt_r;
  reg        oePrev_r;
  reg        dqPrev_r;
  reg        presMode_r;
  always @(posedge clk) begin
    if (sys_rst) begin
      oeLowCnt_r <= 17'h0;
      hiCnt_r <= 17'h0;
      loCnt_r <= 17'h0;
      oePrev_r <= 1'b1;
      dqPrev_r <= 1'b1;
      presMode_r <= 1'b0;
    end else begin
      oeLowCnt_r <= dqOeN ? 17'h0 : oeLowCnt_r + 17'h1;
      hiCnt_r <= dqIn ? hiCnt_r + 17'h1 : 17'h0;
      loCnt_r <= dqIn ? 17'h0 : loCnt_r + 17'h1;
      oePrev_r <= dqOeN;
      dqPrev_r <= dqIn;
      // Our own pull drags the wire at once, so look one cycle back
      if (oePrev_r && !dqOeN)
        presMode_r <= dqPrev_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_rstIdle;
    $fell(sys_rst) |-> dqOeN && !recallPulse_r && recallPage_r == 3'h0;
  endproperty
  a_rstIdle: assert property (p_rstIdle)
    else $error("outputs not idle after reset");
  property p_presWait;
    $fell(dqOeN) && $past(dqIn) |-> hiCnt_r >= 3000 && hiCnt_r <= 12000;
  endproperty
  a_presWait: assert property (p_presWait)
    else $error("presence start off window");
  property p_presLen;
    $rose(dqOeN) && presMode_r |-> oeLowCnt_r >= 12000 && oeLowCnt_r <= 48000;
  endproperty
  a_presLen: assert property (p_presLen)
    else $error("presence length off window");
  property p_rdValid;
    $fell(dqOeN) && !$past(dqIn) |-> loCnt_r <= 2800;
  endproperty
  a_rdValid: assert property (p_rdValid)
    else $error("read bit late");
  property p_rdRelease;
    !dqOeN && !presMode_r |-> oeLowCnt_r < 12000;
  endproperty
  a_rdRelease: assert property (p_rdRelease)
    else $error("read bit held past slot");
  property p_outZero;
    !dqOut;
  endproperty
  a_outZero: assert property (p_outZero)
    else $error("drive value not low");
  property p_recallOne;
    recallPulse_r |=> !recallPulse_r;
  endproperty
  a_recallOne: assert property (p_recallOne)
    else $error("recall pulse too long");
  property p_pageHold;
    !$stable(recallPage_r) |-> recallPulse_r;
  endproperty
  a_pageHold: assert property (p_pageHold)
    else $error("recall page moved alone");
  property p_longLow;
    loCnt_r > 96400 |-> dqOeN;
  endproperty
  a_longLow: assert property (p_longLow)
    else $error("driving during bus reset");
endmodule
bind swsa_slave swsa_slave_chk chk (.clk(clk), .sys_rst(sys_rst),
  .dqIn(dqIn), .dqOut(dqOut), .dqOeN(dqOeN),
  .recallPulse_r(recallPulse_r), .recallPage_r(recallPage_r));

// ---- bench/swsa_master_model.sv ----
`timescale 1ns/1ps
module swsa_master_model (
  input  wire clk,
  input  wire dqOeN,
  input  wire dqOut,
  output wire dq
);
  // ********************************
  // Bus master with pull-up
  // ********************************
  localparam US = 200;
  reg mLow = 1'b0;
  // Released wire floats to the pull-up level
  assign dq = !(mLow || (!dqOeN && !dqOut));
  task waitUs(input integer n);
    repeat (n * US) @(posedge clk);
  endtask
  // Returns presence wait and length in clocks
  task busReset(output integer w, output integer l);
    mLow <= 1'b1;
    waitUs(490);
    mLow <= 1'b0;
    w = 0;
    while (dqOeN !== 1'b0 && w < 80 * US) begin
      @(posedge clk);
      w = w + 1;
    end
    l = 0;
    while (dqOeN === 1'b0 && l < 300 * US) begin
      @(posedge clk);
      l = l + 1;
    end
    waitUs(10);
  endtask
  task writeBit(input b);
    mLow <= 1'b1;
    waitUs(2);
    if (b)
      mLow <= 1'b0;
    waitUs(60);
    mLow <= 1'b0;
    waitUs(2);
  endtask
  task readBit(output b);
    mLow <= 1'b1;
    waitUs(1);
    mLow <= 1'b0;
    waitUs(13);
    b = dq;
    waitUs(50);
  endtask
  task writeByte(input [7:0] v);
    integer i;
    for (i = 0; i < 8; i = i + 1)
      writeBit(v[i]);
  endtask
  task readByte(output [7:0] v);
    integer i;
    for (i = 0; i < 8; i = i + 1)
      readBit(v[i]);
  endtask
  task txn(input [7:0] cmd, input [7:0] pg, output ok);
    integer w;
    integer l;
    busReset(w, l);
    ok = w >= 3000 && w <= 12000 && l >= 12000 && l <= 48000;
    writeByte(8'hcc);
    writeByte(cmd);
    writeByte(pg);
  endtask
endmodule

// ---- bench/single_wire_slave_accum_read_tb_top.sv ----
`timescale 1ns/1ps
module single_wire_slave_accum_read_tb_top;
  // ********************************
  // Stimulus and checks
  // ********************************
  reg         clk;
  reg         sysRst;
  reg         memWrEn;
  reg  [5:0]  memWrAddr;
  reg  [7:0]  memWrData;
  reg  [7:0]  integrated_current_total;
  reg  [15:0] chg;
  reg  [15:0] dis;
  wire        dq;
  wire        dqOut;
  wire        dqOeN;
  wire        recallPulse;
  wire [2:0]  recallPage;
  reg  [7:0]  mem [0:63];
  integer     fails;
  integer     compares;
  integer     pulses = 0;
  swsa_slave uut (.clk(clk), .sys_rst(sysRst), .dqIn(dq), .dqOut(dqOut),
    .dqOeN(dqOeN), .memWrEn(memWrEn), .memWrAddr(memWrAddr),
    .memWrData(memWrData), .integratedCurrentTotal(integrated_current_total),
    .chargeTotalCounter(chg), .dischargeTotalCounter(dis),
    .recallPulse_r(recallPulse), .recallPage_r(recallPage));
  swsa_master_model m (.clk(clk), .dqOeN(dqOeN), .dqOut(dqOut), .dq(dq));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
    if (recallPulse === 1'b1)
      pulses <= pulses + 1;
  task cmp(input [15:0] got, input [15:0] exp, input string msg);
    compares = compares + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("BAD %0t %0s got %h", $time, msg, got);
    end
  endtask
  function [7:0] crc8(input [7:0] c, input [7:0] d);
    integer i;
    reg fb;
    begin
      crc8 = c;
      for (i = 0; i < 8; i = i + 1) begin
        fb = crc8[0] ^ d[i];
        crc8 = (crc8 >> 1) ^ (fb ? 8'h8c : 8'h00);
      end
    end
  endfunction
  task fillStore;
    integer i;
    for (i = 0; i < 64; i = i + 1) begin
      @(posedge clk);
      memWrEn <= 1'b1;
      memWrAddr <= i[5:0];
      memWrData <= 8'h5a ^ i[7:0];
      mem[i] = 8'h5a ^ i[7:0];
    end
    @(posedge clk);
    memWrEn <= 1'b0;
  endtask
  task testPresence;
    integer w;
    integer l;
    m.busReset(w, l);
    cmp(w >= 3000 && w <= 12000, 1, "presence wait");
    cmp(l >= 12000 && l <= 48000, 1, "presence length");
    $display("done presence");
  endtask
  // Live inputs move afterwards, so a read must show the captured copy
  task testRecall(input [2:0] pg);
    integer p0;
    reg ok;
    p0 = pulses;
    m.txn(8'hb8, {5'h00, pg}, ok);
    cmp(ok, 1, "presence before recall");
    cmp(pulses - p0, 1, "recall pulses");
    cmp(recallPage, pg, "recall page");
    if (pg == 3'h1)
      mem[12] = integrated_current_total;
    if (pg == 3'h7)
      {mem[63], mem[62], mem[61], mem[60]} = {dis, chg};
    integrated_current_total <= ~integrated_current_total;
    chg <= chg + 16'h0101;
    dis <= dis ^ 16'hffff;
    $display("done recall");
  endtask
  // Short counts leave the read cut off mid-page
  task testRead(input [2:0] pg, input integer n);
    integer k;
    reg [7:0] b;
    reg [7:0] c;
    reg [7:0] e;
    reg ok;
    c = 8'h00;
    m.txn(8'hbe, {5'h00, pg}, ok);
    cmp(ok, 1, "presence before read");
    for (k = 0; k < n; k = k + 1) begin
      m.readByte(b);
      e = (k < 8) ? mem[{pg, 3'h0} + k] : c;
      cmp(b, e, "scratchpad byte");
      c = crc8(c, e);
    end
    $display("done read");
  endtask
  task testBadCmd;
    reg [7:0] b;
    reg ok;
    m.txn(8'h44, 8'h00, ok);
    cmp(ok, 1, "presence before bad command");
    m.readByte(b);
    cmp(b, 8'hff, "unknown command answered");
    m.txn(8'hbe, 8'h09, ok);
    cmp(ok, 1, "presence before bad page");
    m.readByte(b);
    cmp(b, 8'hff, "bad page answered");
    $display("done bad command");
  endtask
  // A system reset mid-frame must drop the link and the recall page
  task testSysRst;
    sysRst <= 1'b1;
    repeat (2) @(posedge clk);
    sysRst <= 1'b0;
    @(posedge clk);
    cmp(dqOeN, 1'b1, "drive after system reset");
    cmp(recallPage, 3'h0, "page after system reset");
    $display("done system reset");
  endtask
  task summarize;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    fails = 0;
    compares = 0;
    sysRst = 1'b1;
    memWrEn = 1'b0;
    memWrAddr = 6'h00;
    memWrData = 8'h00;
    integrated_current_total = 8'h7b;
    chg = 16'h3c5a;
    dis = 16'h96e1;
    repeat (16) @(posedge clk);
    sysRst <= 1'b0;
    fillStore;
    testPresence;
    testRecall(3'h7);
    testRead(3'h7, 9);
    testRecall(3'h1);
    testRead(3'h1, 9);
    testBadCmd;
    testRead(3'h0, 3);
    testSysRst;
    testPresence;
    summarize;
  end
endmodule
